// >>> rtl/adcsro_top.sv
// Serial readout control of a 20-bit converter: word register, ready flag, two serial modes
`timescale 1ns/100ps
module adcsro_top
(
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic mode_self_clock_in,
  input wire logic cal_strobe_in,
  input wire logic trim_type_select_a_in,
  input wire logic trim_type_select_b_in,
  input wire logic sleep_n_in,
  input wire logic polarity_range_select_in,
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic result_valid_in,
  output logic result_ready_out,
  input wire logic [19:0] result_data_in,
  output logic sclk_out,
  output logic sclk_oe_n_out,
  output logic serial_out_line_out,
  output logic serial_out_line_oe_n_out,
  output logic word_valid_n_out,
  output logic standby_out,
  output logic bipolar_out,
  output logic calibrating_out,
  output logic [1:0] trim_type_out,
  output logic sys_offset_cal_out
);
  logic rst_s1_ff;
  logic rst_n;
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rst_s1_ff <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_ff <= 1'b1;
      rst_n <= rst_s1_ff;
    end
  end

  // Three-stage samplers for pins from outside this clock
  logic [2:0] cs_sync_ff;
  logic [2:0] sck_sync_ff;
  logic [2:0] cal_sync_ff;
  logic [2:0] slp_sync_ff;
  logic [2:0] mode_sync_ff;
  logic [2:0] pol_sync_ff;
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_sync_ff <= 3'h7;
      sck_sync_ff <= 3'h0;
      cal_sync_ff <= 3'h0;
      slp_sync_ff <= 3'h7;
      mode_sync_ff <= 3'h0;
      pol_sync_ff <= 3'h0;
    end
    else
    begin
      cs_sync_ff <= {cs_sync_ff[1:0], cs_n_in};
      sck_sync_ff <= {sck_sync_ff[1:0], sclk_in};
      cal_sync_ff <= {cal_sync_ff[1:0], cal_strobe_in};
      slp_sync_ff <= {slp_sync_ff[1:0], sleep_n_in};
      mode_sync_ff <= {mode_sync_ff[1:0], mode_self_clock_in};
      pol_sync_ff <= {pol_sync_ff[1:0], polarity_range_select_in};
    end
  end
  wire cs_fall = !cs_sync_ff[1] && cs_sync_ff[2];
  wire cs_high = cs_sync_ff[1] && cs_sync_ff[2];
  wire sck_fall = !sck_sync_ff[1] && sck_sync_ff[2];
  wire cal_high = cal_sync_ff[1] && cal_sync_ff[2];
  wire cal_rise = cal_sync_ff[1] && !cal_sync_ff[2];
  wire cal_fall = !cal_sync_ff[1] && cal_sync_ff[2];
  wire awake = slp_sync_ff[1] && slp_sync_ff[2];
  wire self_mode = mode_sync_ff[1] && mode_sync_ff[2];
  wire pol_steady = (pol_sync_ff[1] == pol_sync_ff[2]);

  // Strobe held long resets the block, calibration follows its fall
  logic [2:0] cal_cnt_ff;
  logic cal_reset_ff;
  logic [11:0] cal_run_ff;
  logic [1:0] trim_ff;
  wire cal_long = (cal_cnt_ff == adcsro_pkg::CAL_HOLD_CYCLES) && cal_high;
  wire [2:0] nxt_cal_cnt = !cal_high ? 3'h0 : (cal_long ? cal_cnt_ff : cal_cnt_ff + 3'h1);
  wire soft_reset = cal_long || cal_reset_ff;
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cal_cnt_ff <= 3'h0;
      cal_reset_ff <= 1'b0;
      cal_run_ff <= 12'h000;
      trim_ff <= 2'h0;
    end
    else
    begin
      cal_cnt_ff <= nxt_cal_cnt;
      if (cal_rise)
        trim_ff <= {trim_type_select_b_in, trim_type_select_a_in};
      if (cal_long)
        cal_reset_ff <= 1'b1;
      else if (cal_fall)
        cal_reset_ff <= 1'b0;
      if (cal_fall && cal_reset_ff)
        cal_run_ff <= adcsro_pkg::CAL_RUN_CYCLES;
      else if (cal_run_ff != 12'h000)
        cal_run_ff <= cal_run_ff - 12'h001;
    end
  end

  // Result path: new word passes the buffer, then loads the output register
  logic buf_valid;
  logic [19:0] buf_data;
  logic [19:0] out_word_ff;
  logic [2:0] blank_ff;
  logic have_word_ff;
  adcsro_pkg::adcsro_state_t state_ff;
  wire busy = (state_ff != adcsro_pkg::ADCSRO_IDLE);
  // A held word is never overwritten, so a slow reader loses nothing
  wire load = buf_valid && !busy && !have_word_ff && (blank_ff == 3'h0) && awake;
  adcsro_buf2 u_buf
  (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n),
    .flush_in(soft_reset),
    .in_valid_in(result_valid_in && awake && !soft_reset),
    .in_ready_out(result_ready_out),
    .in_data_in(result_data_in),
    .out_valid_out(buf_valid),
    .out_ready_in(load),
    .out_data_out(buf_data)
  );

  // Self clock: four-phase divider, high one phase in four
  logic [1:0] div_ff;
  logic sck_o_ff;
  // Shift only after a driven high phase, so no bit leaves unclocked
  wire self_fall = (div_ff == adcsro_pkg::SCLK_FALL_PHASE) && sck_o_ff;
  wire shift_edge = self_mode ? self_fall : sck_fall;
  logic [4:0] bit_ff;
  logic sdo_ff;
  logic sdo_oe_n_ff;
  logic sck_oe_n_ff;
  logic word_valid_n_n_ff;
  wire last_bit = (bit_ff == adcsro_pkg::LAST_BIT);

  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_ff <= 2'h0;
      state_ff <= adcsro_pkg::ADCSRO_IDLE;
      bit_ff <= 5'h00;
      out_word_ff <= 20'h00000;
      have_word_ff <= 1'b0;
      blank_ff <= 3'h0;
      sdo_ff <= 1'b0;
      sdo_oe_n_ff <= 1'b1;
      sck_o_ff <= 1'b0;
      sck_oe_n_ff <= 1'b1;
    end
    else if (soft_reset || !awake)
    begin
      div_ff <= 2'h0;
      state_ff <= adcsro_pkg::ADCSRO_IDLE;
      bit_ff <= 5'h00;
      have_word_ff <= 1'b0;
      blank_ff <= 3'h0;
      sdo_oe_n_ff <= 1'b1;
      sck_oe_n_ff <= 1'b1;
      sck_o_ff <= 1'b0;
    end
    else
    begin
      div_ff <= (div_ff == adcsro_pkg::SCLK_DIV_LAST) ? 2'h0 : div_ff + 2'h1;
      if (load)
      begin
        out_word_ff <= buf_data;
        have_word_ff <= 1'b1;
        blank_ff <= adcsro_pkg::LOAD_BLANK_CYCLES;
      end
      else if (blank_ff != 3'h0)
        blank_ff <= blank_ff - 3'h1;
      case (state_ff)
        adcsro_pkg::ADCSRO_IDLE:
        begin
          if (cs_fall && have_word_ff && blank_ff == 3'h0)
          begin
            state_ff <= adcsro_pkg::ADCSRO_SHIFT;
            bit_ff <= 5'h00;
            sdo_ff <= out_word_ff[adcsro_pkg::WORD_BITS - 1];
            sdo_oe_n_ff <= 1'b0;
            sck_oe_n_ff <= !self_mode;
          end
        end
        adcsro_pkg::ADCSRO_SHIFT:
        begin
          if (self_mode)
            sck_o_ff <= (div_ff == adcsro_pkg::SCLK_HIGH_PHASE);
          if (shift_edge)
          begin
            if (last_bit || cs_high)
            begin
              state_ff <= adcsro_pkg::ADCSRO_FINISH;
              sck_o_ff <= 1'b0;
            end
            else
            begin
              bit_ff <= bit_ff + 5'h01;
              sdo_ff <= out_word_ff[5'(adcsro_pkg::LAST_BIT - bit_ff - 5'h01)];
            end
            if (last_bit)
              have_word_ff <= load;
          end
        end
        default:
        begin
          state_ff <= adcsro_pkg::ADCSRO_IDLE;
          sdo_oe_n_ff <= 1'b1;
          sck_oe_n_ff <= 1'b1;
          sck_o_ff <= 1'b0;
        end
      endcase
    end
  end

  wire nxt_word_valid_n_n = !(have_word_ff && blank_ff == 3'h0) || (blank_ff != 3'h0);
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      word_valid_n_n_ff <= 1'b1;
    else
      word_valid_n_n_ff <= nxt_word_valid_n_n;
  end

  logic standby_ff;
  logic bipolar_ff;
  logic cal_ff;
  logic sys_off_ff;
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      standby_ff <= 1'b0;
      bipolar_ff <= 1'b0;
      cal_ff <= 1'b0;
      sys_off_ff <= 1'b0;
    end
    else
    begin
      standby_ff <= !awake;
      if (pol_steady)
        bipolar_ff <= pol_sync_ff[2];
      cal_ff <= soft_reset || (cal_run_ff != 12'h000);
      sys_off_ff <= (cal_run_ff != 12'h000) && !trim_ff[1];
    end
  end

  assign sclk_out = sck_o_ff;
  assign sclk_oe_n_out = sck_oe_n_ff;
  assign serial_out_line_out = sdo_ff;
  assign serial_out_line_oe_n_out = sdo_oe_n_ff;
  assign word_valid_n_out = word_valid_n_n_ff;
  assign standby_out = standby_ff;
  assign bipolar_out = bipolar_ff;
  assign calibrating_out = cal_ff;
  assign trim_type_out = trim_ff;
  assign sys_offset_cal_out = sys_off_ff;

  chk_load_blanks_valid: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    load |=> ##1 word_valid_n_out [*4])
    else $error("word valid not held high after load");
  chk_cal_long_reset: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    cal_long |=> (state_ff == adcsro_pkg::ADCSRO_IDLE) && sdo_oe_n_ff)
    else $error("long strobe did not reset shifter");
  chk_sleep_standby: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    !awake |=> standby_out && sdo_oe_n_ff)
    else $error("sleep did not enter standby");
  chk_bipolar_follow: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    pol_steady |=> bipolar_out == $past(pol_sync_ff[2]))
    else $error("polarity output wrong");
  chk_self_clock_duty: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    $rose(sclk_out) |=> !sclk_out)
    else $error("self clock high longer than one phase");
  chk_start_on_cs: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    $fell(sdo_oe_n_ff) |-> $past(cs_fall))
    else $error("data driven without chip select fall");
  chk_trim_sample: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    cal_rise |=> trim_ff == $past({trim_type_select_b_in, trim_type_select_a_in}))
    else $error("trim type not sampled at strobe rise");
  chk_release_after: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    state_ff == adcsro_pkg::ADCSRO_FINISH |=> sdo_oe_n_ff && sck_oe_n_ff)
    else $error("lines not released after word");
endmodule : adcsro_top

// >>> pkg/adcsro_pkg.sv
// Constants for the converter serial readout control block
package adcsro_pkg;
  localparam int unsigned WORD_BITS = 20;
  localparam logic [4:0] LAST_BIT = 5'h13;
  localparam logic [2:0] CAL_HOLD_CYCLES = 3'h4;
  localparam logic [2:0] LOAD_BLANK_CYCLES = 3'h4;
  localparam logic [1:0] SCLK_DIV_LAST = 2'h3;
  localparam logic [1:0] SCLK_HIGH_PHASE = 2'h0;
  localparam logic [1:0] SCLK_FALL_PHASE = 2'h1;
  localparam logic [1:0] SCLK_RISE_PHASE = 2'h0;
  localparam logic [11:0] CAL_RUN_CYCLES = 12'h040;
  localparam logic [1:0] TRIM_SYS_OFFSET = 2'h0;

  typedef enum logic [1:0] {
    ADCSRO_IDLE = 2'h0,
    ADCSRO_SHIFT = 2'h1,
    ADCSRO_FINISH = 2'h3
  } adcsro_state_t;
endpackage : adcsro_pkg

// >>> rtl/adcsro_buf2.sv
// Two-entry word buffer between result source and serial shifter
`timescale 1ns/100ps
module adcsro_buf2
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic flush_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [19:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [19:0] out_data_out
);
  logic [19:0] mem_ff [0:1];
  logic rd_ptr_ff;
  logic wr_ptr_ff;
  logic [1:0] cnt_ff;
  logic ready_ff;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;
  wire [1:0] nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};

  // Ready is registered so that the port comes straight from a flip-flop
  assign in_ready_out = ready_ff;
  assign out_valid_out = (cnt_ff != 2'h0);
  assign out_data_out = mem_ff[rd_ptr_ff];

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rd_ptr_ff <= 1'b0;
      wr_ptr_ff <= 1'b0;
      cnt_ff <= 2'h0;
      ready_ff <= 1'b0;
      mem_ff[0] <= 20'h00000;
      mem_ff[1] <= 20'h00000;
    end
    else if (flush_in)
    begin
      rd_ptr_ff <= 1'b0;
      wr_ptr_ff <= 1'b0;
      cnt_ff <= 2'h0;
      ready_ff <= 1'b1;
    end
    else
    begin
      if (push)
      begin
        mem_ff[wr_ptr_ff] <= in_data_in;
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop)
        rd_ptr_ff <= ~rd_ptr_ff;
      cnt_ff <= nxt_cnt;
      ready_ff <= (nxt_cnt != 2'h2);
    end
  end

  chk_buf_count: assert property (@(posedge clk_in) disable iff (!rst_n_in) cnt_ff <= 2'h2)
    else $error("buffer count above two");
  chk_buf_ready_full: assert property (@(posedge clk_in) disable iff (!rst_n_in) (cnt_ff == 2'h2) |-> !in_ready_out)
    else $error("buffer full but ready shown");
endmodule : adcsro_buf2

// >>> test/adcsro_host_model.sv
// Host serial port model that clocks words out of the readout block or, in self clock mode, samples them on the block's clock
`timescale 1ns/100ps
module adcsro_host_model
(
  input wire logic clk_in,
  input wire logic line_in,
  input wire logic sclk_in,
  output logic cs_n_out,
  output logic sclk_out
);
  logic [19:0] rx;
  initial
  begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    rx = '0;
  end
  // Bit clock of 180 ns: low 7 cycles so the next bit has settled, high 2
  task automatic read_ext(input int n);
    rx = '0;
    @(posedge clk_in) cs_n_out <= 1'b0;
    repeat (10) @(posedge clk_in);
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk_in) rx = {rx[18:0], line_in};
      @(posedge clk_in) sclk_out <= 1'b1;
      repeat (2) @(posedge clk_in);
      sclk_out <= 1'b0;
      repeat (6) @(posedge clk_in);
    end
    cs_n_out <= 1'b1;
    // Early end: one more falling bit clock with select high
    if (n < 20)
    begin
      @(posedge clk_in) sclk_out <= 1'b1;
      repeat (2) @(posedge clk_in);
      sclk_out <= 1'b0;
    end
  endtask : read_ext
  // Self clock: take each bit at the rise of the block's bit clock
  task automatic read_self();
    rx = '0;
    @(posedge clk_in) cs_n_out <= 1'b0;
    for (int i = 0; i < 20; i++)
    begin
      do @(negedge clk_in); while (sclk_in !== 1'b0);
      do @(negedge clk_in); while (sclk_in !== 1'b1);
      rx = {rx[18:0], line_in};
    end
    do @(negedge clk_in); while (sclk_in !== 1'b0);
    @(posedge clk_in) cs_n_out <= 1'b1;
  endtask : read_self
endmodule : adcsro_host_model

// >>> test/testbench.sv
// Self-checking bench for the serial readout control block
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic mode = 1'b0;
  logic cal = 1'b0;
  logic ta = 1'b0;
  logic tbs = 1'b0;
  logic slp_n = 1'b1;
  logic pol = 1'b0;
  logic rv = 1'b0;
  logic [19:0] rd = '0;
  logic cs_n, sclk_h, rr, sclk_d, sclk_oe_n, sd, sd_oe_n, wv_n, stby, bip, calib, soc, line;
  logic [1:0] tt;
  int n_fail = 0;
  int cmp_count = 0;
  assign line = sd_oe_n ? 1'bz : sd;
  always #10 clk = ~clk;
  adcsro_top adcsro_top_i (.sys_clk_in(clk), .nrst_in(nrst), .mode_self_clock_in(mode), .cal_strobe_in(cal),
    .trim_type_select_a_in(ta), .trim_type_select_b_in(tbs), .sleep_n_in(slp_n), .polarity_range_select_in(pol),
    .cs_n_in(cs_n), .sclk_in(sclk_h), .result_valid_in(rv), .result_ready_out(rr), .result_data_in(rd),
    .sclk_out(sclk_d), .sclk_oe_n_out(sclk_oe_n), .serial_out_line_out(sd), .serial_out_line_oe_n_out(sd_oe_n),
    .word_valid_n_out(wv_n), .standby_out(stby), .bipolar_out(bip), .calibrating_out(calib),
    .trim_type_out(tt), .sys_offset_cal_out(soc));
  adcsro_host_model adcsro_host_model_i (.clk_in(clk), .line_in(line), .sclk_in(sclk_d), .cs_n_out(cs_n),
    .sclk_out(sclk_h));
  task automatic chk_bit(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: %s is %b", $time, what, got);
    end
  endtask : chk_bit
  task automatic chk_word(input logic [19:0] got, input logic [19:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  task automatic push(input logic [19:0] w);
    @(posedge clk);
    rd <= w;
    rv <= 1'b1;
    @(negedge clk);
    while (rr !== 1'b1) @(negedge clk);
    @(posedge clk) rv <= 1'b0;
  endtask : push
  // Ready flag must stay high a few cycles after a load, then fall within a bound
  task automatic await_word(input int lo);
    int c;
    c = 0;
    while (wv_n !== 1'b0 && c < 60)
    begin
      @(negedge clk);
      c++;
    end
    chk_bit(c >= lo && c < 60, 1'b1, "ready flag timing");
  endtask : await_word
  task automatic wait_cycles(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_cycles
  task automatic t_ext(input logic [19:0] w);
    push(w);
    await_word(5);
    chk_bit(wv_n, 1'b0, "ready flag held");
    adcsro_host_model_i.read_ext(20);
    chk_word(adcsro_host_model_i.rx, w);
    chk_bit(sclk_oe_n, 1'b1, "bit clock enable");
    wait_cycles(6);
    chk_bit(wv_n, 1'b1, "ready flag after word");
    chk_bit(sd_oe_n, 1'b1, "data released");
  endtask : t_ext
  task automatic t_buf();
    push(20'h11111);
    push(20'h22222);
    push(20'h33333);
    @(negedge clk);
    chk_bit(rr, 1'b0, "buffer full");
    for (int i = 1; i < 4; i++)
    begin
      await_word(1);
      adcsro_host_model_i.read_ext(20);
      chk_word(adcsro_host_model_i.rx, 20'(20'h11111 * i));
      chk_bit(wv_n, 1'b1, "ready flag after buffered word");
      wait_cycles(4);
    end
  endtask : t_buf
  task automatic t_self();
    @(posedge clk) mode <= 1'b1;
    wait_cycles(6);
    push(20'hc0ffe);
    await_word(5);
    adcsro_host_model_i.read_self();
    chk_word(adcsro_host_model_i.rx, 20'hc0ffe);
    wait_cycles(6);
    chk_bit(wv_n, 1'b1, "ready flag after word");
    chk_bit(sclk_oe_n, 1'b1, "bit clock released");
    @(posedge clk) mode <= 1'b0;
    wait_cycles(6);
  endtask : t_self
  task automatic t_abort();
    push(20'hb7d21);
    await_word(5);
    adcsro_host_model_i.read_ext(5);
    chk_word({15'h0, adcsro_host_model_i.rx[4:0]}, {15'h0, 5'h16});
    wait_cycles(6);
    chk_bit(sd_oe_n, 1'b1, "data released early");
  endtask : t_abort
  task automatic t_levels();
    @(posedge clk) pol <= 1'b1;
    wait_cycles(6);
    chk_bit(bip, 1'b1, "bipolar");
    @(posedge clk) pol <= 1'b0;
    slp_n <= 1'b0;
    wait_cycles(6);
    chk_bit(bip, 1'b0, "unipolar");
    chk_bit(stby, 1'b1, "standby");
    @(posedge clk) slp_n <= 1'b1;
    wait_cycles(6);
    chk_bit(stby, 1'b0, "awake");
  endtask : t_levels
  task automatic t_cal();
    push(20'h5a5a5);
    await_word(5);
    @(posedge clk) ta <= 1'b1;
    tbs <= 1'b0;
    @(posedge clk) cal <= 1'b1;
    repeat (8) @(posedge clk);
    cal <= 1'b0;
    wait_cycles(6);
    chk_bit(wv_n, 1'b1, "word dropped by strobe");
    chk_bit(tt[0], 1'b1, "trim type a");
    chk_bit(tt[1], 1'b0, "trim type b");
    chk_bit(soc, 1'b1, "system offset trim");
    chk_bit(calib, 1'b1, "calibration running");
  endtask : t_cal
  initial
  begin
    #200000;
    n_fail++;
    final_report();
  end
  initial
  begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    wait_cycles(8);
    chk_bit(wv_n, 1'b1, "ready flag at reset");
    chk_bit(sd_oe_n, 1'b1, "data idle");
    t_ext(20'ha5c3e);
    t_buf();
    t_self();
    t_abort();
    t_levels();
    t_cal();
    final_report();
  end
endmodule : testbench
